// File: src/motor_cfg_pkg.sv
// Constants and state types for the regulator, delay and demagnetization block.
// Assumes a 100 MHz core clock and a 16-bit serial frame from the controller.
package motor_cfg_pkg;

   localparam int           CLK_PERIOD_NS  = 10;
   ////////////////////////////////////////////////////////////////////////////
   // Register map (serial port addresses)
   localparam logic [5:0]   ADDR_RECT      = 6'h07;
   localparam logic [5:0]   ADDR_REG_CTRL  = 6'h08;
   localparam logic [5:0]   ADDR_DELAY     = 6'h0C;
   localparam logic [7:0]   RECT_RESET     = 8'h00;
   localparam logic [7:0]   REG_CTRL_RESET = 8'h00;
   localparam logic [7:0]   DELAY_RESET    = 8'h00;
   // Writable bits; the rest are read-only zero
   localparam logic [7:0]   RECT_WMASK     = 8'hFF;
   localparam logic [7:0]   REG_CTRL_WMASK = 8'h3F;
   localparam logic [7:0]   DELAY_WMASK    = 8'h1F;
   // Field positions
   localparam int           BIT_SYNC_RECT  = 2;
   localparam int           BIT_ASYNC_RECT = 3;
   localparam int           BIT_SEQ_OFF    = 4;
   localparam int           BIT_CUR_LIM    = 3;
   localparam int           BIT_VSEL_HI    = 2;
   localparam int           BIT_VSEL_LO    = 1;
   localparam int           BIT_REG_OFF    = 0;
   localparam int           BIT_DLY_EN     = 4;
   localparam int           BIT_TGT_HI     = 3;
   ////////////////////////////////////////////////////////////////////////////
   // Serial frame: bit 15 read flag, 14-9 address, 8 parity, 7-0 data
   localparam logic [4:0]   FRAME_BITS     = 5'h10;
   localparam logic [4:0]   HDR_BITS       = 5'h08;
   localparam logic [4:0]   CNT_MAX        = 5'h1F;
   localparam int           RW_BIT         = 15;
   localparam int           IN_W           = 15;
   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int           DLY_STEP_NS    = 200;
   localparam int           DLY_STEP_CYC   = (DLY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int           DEAD_NS        = 100;
   localparam int           QUAL_NS        = 200;
   localparam logic [7:0]   DEAD_CYCLES    = 8'((DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0]   QUAL_CYCLES    = 8'((QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Code 0 is no delay, code 1 is 0.4 us, each further code adds one step
   function automatic logic [8:0] delay_cycles(input logic [3:0] code);
      if (code == 4'h0) begin
         return 9'h000;
      end
      return 9'((int'(code) + 1) * DLY_STEP_CYC);
   endfunction

   typedef struct packed {
      logic [IN_W-1:0] sync1;
      logic [IN_W-1:0] sync2;
      logic            sclk_prev;
      logic [15:0]     shift;
      logic [4:0]      bit_cnt;
      logic [7:0]      dout;
      logic            sdo_oe_n;
      logic [7:0]      rect_reg;
      logic [7:0]      reg_ctrl;
      logic [7:0]      delay_reg;
   } top_state_t;

   typedef struct packed {
      logic       eff_h;
      logic       eff_l;
      logic       pend_h;
      logic       pend_l;
      logic [8:0] dcnt;
      logic [7:0] off_cnt;
      logic [7:0] qual_h;
      logic [7:0] qual_l;
      logic       gate_h;
      logic       gate_l;
      logic       dmg_h;
      logic       dmg_l;
   } phase_state_t;

endpackage

// File: src/motor_cfg_top.sv
// Serial register bank for regulator and delay settings, driving three phase engines.
// Assumes a controller on the 16-bit serial port and PWM inputs from outside the clock domain.
//
// Summary of operation
// - Regulator control at 0x8, resets zero
// - Bit 4 set disables regulator sequencing
// - Bit 3 picks 600 or 150 mA
// - Bits 2-1 pick regulator output voltage
// - Bit 0 set turns regulator off
// - Delay compensation at 0xC, resets zero
// - Bit 4 enables delay compensation
// - Bits 3-0 give target delay code
// - Demag turns FET on while diode conducts
// - Demag needs both rectification enables set
// - Without demag, dead time and diode only
// - Comparators tell voltage against threshold
// - Qualified comparator after dead time turns FET on
// - Voltage below threshold turns FET off
// - Compensation delays both directions to target
// - Rectification enables at bits 2 and 3
// - Dead time is larger of driver and controller
`timescale 1ns/100ps
module motor_cfg_top
   import motor_cfg_pkg::*;
(
   input  wire logic       ref_clk,                      // Core clock
   input  wire logic       rst_n,                        // Async reset
   input  wire logic       spi_scs_n,                    // Serial chip select
   input  wire logic       spi_sclk,                     // Serial clock
   input  wire logic       spi_sdi,                      // Serial data in
   output logic            spi_sdo_out,                  // Serial data out level
   output logic            spi_sdo_oe_n,                 // Serial data out enable
   input  wire logic [2:0] pwm_high_in,                  // High-side PWM per phase
   input  wire logic [2:0] pwm_low_in,                   // Low-side PWM per phase
   input  wire logic [2:0] demag_comparator_high,        // High-side comparators
   input  wire logic [2:0] demag_comparator_low,         // Low-side comparators
   output logic [2:0]      gate_high,                    // High-side FET on
   output logic [2:0]      gate_low,                     // Low-side FET on
   output logic            regulator_sequencing_off,     // Sequencing disabled
   output logic            regulator_current_limit_sel,  // 1 = low limit
   output logic [1:0]      regulator_voltage_sel,        // Output voltage code
   output logic            regulator_off                 // Regulator disabled
);
   import motor_cfg_pkg::*;

   top_state_t    s;
   top_state_t    nxt_s;
   phase_cfg_if   cfg ();
   logic          scs_n;
   logic          sclk;
   logic          sdi;
   logic [2:0]    ph_s;
   logic [2:0]    pl_s;
   logic [2:0]    ch_s;
   logic [2:0]    cl_s;
   logic          frame_end;
   logic          wr_commit;

   function automatic logic [7:0] reg_read(input top_state_t st, input logic [5:0] addr);
      case (addr)
         ADDR_RECT:     return st.rect_reg;
         ADDR_REG_CTRL: return st.reg_ctrl;
         ADDR_DELAY:    return st.delay_reg;
         default:       return 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Every pin passes two flops; only sync2 is read by logic
   always_comb begin
      nxt_s       = s;
      nxt_s.sync1 = {demag_comparator_low, demag_comparator_high, pwm_low_in, pwm_high_in,
                     spi_sdi, spi_sclk, spi_scs_n};
      nxt_s.sync2 = s.sync1;
      scs_n       = s.sync2[0];
      sclk        = s.sync2[1];
      sdi         = s.sync2[2];
      nxt_s.sclk_prev = sclk;
      // Frames of any length other than 16 bits are dropped
      frame_end = scs_n && !s.sdo_oe_n && (s.bit_cnt == FRAME_BITS);
      wr_commit = frame_end && !s.shift[RW_BIT];
      if (scs_n) begin
         nxt_s.bit_cnt  = 5'h00;
         nxt_s.dout     = 8'h00;
         nxt_s.sdo_oe_n = 1'b1;
         if (wr_commit) begin
            case (s.shift[14:9])
               ADDR_RECT:     nxt_s.rect_reg  = s.shift[7:0] & RECT_WMASK;
               ADDR_REG_CTRL: nxt_s.reg_ctrl  = s.shift[7:0] & REG_CTRL_WMASK;
               ADDR_DELAY:    nxt_s.delay_reg = s.shift[7:0] & DELAY_WMASK;
               default:       nxt_s.rect_reg  = s.rect_reg;
            endcase
         end
      end else begin
         nxt_s.sdo_oe_n = 1'b0;
         if (sclk && !s.sclk_prev) begin
            nxt_s.shift   = {s.shift[14:0], sdi};
            nxt_s.bit_cnt = (s.bit_cnt == CNT_MAX) ? CNT_MAX : s.bit_cnt + 5'h01;
         end
         // Data leaves on falling edges; header slots return zero
         if (!sclk && s.sclk_prev) begin
            if (s.bit_cnt == HDR_BITS) begin
               nxt_s.dout = reg_read(s, s.shift[6:1]);
            end else begin
               nxt_s.dout = {s.dout[6:0], 1'b0};
            end
         end
      end
      {cl_s, ch_s, pl_s, ph_s} = s.sync2[IN_W-1:3];
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s           <= '0;
         // Select syncs start deselected so no phantom frame follows reset
         s.sync1[0]  <= 1'b1;
         s.sync2[0]  <= 1'b1;
         s.sdo_oe_n  <= 1'b1;
         s.rect_reg  <= RECT_RESET;
         s.reg_ctrl  <= REG_CTRL_RESET;
         s.delay_reg <= DELAY_RESET;
      end else begin
         s <= nxt_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign spi_sdo_out                 = s.dout[7];
   assign spi_sdo_oe_n                = s.sdo_oe_n;
   assign regulator_sequencing_off    = s.reg_ctrl[BIT_SEQ_OFF];
   assign regulator_current_limit_sel = s.reg_ctrl[BIT_CUR_LIM];
   assign regulator_voltage_sel       = s.reg_ctrl[BIT_VSEL_HI:BIT_VSEL_LO];
   assign regulator_off               = s.reg_ctrl[BIT_REG_OFF];

   assign cfg.delay_comp_enable = s.delay_reg[BIT_DLY_EN];
   assign cfg.delay_cycles      = delay_cycles(s.delay_reg[BIT_TGT_HI:0]);
   assign cfg.demag_enable      = s.rect_reg[BIT_SYNC_RECT] & s.rect_reg[BIT_ASYNC_RECT];

   for (genvar p = 0; p < 3; p++) begin : g_phase
      phase_engine u_phase (
         .ref_clk   (ref_clk),
         .rst_n     (rst_n),
         .cfg       (cfg.dst),
         .pwm_high  (ph_s[p]),
         .pwm_low   (pl_s[p]),
         .comp_high (ch_s[p]),
         .comp_low  (cl_s[p]),
         .gate_high (gate_high[p]),
         .gate_low  (gate_low[p])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   ctrl_write_a: assert property (wr_commit && s.shift[14:9] == ADDR_REG_CTRL
                                  |=> s.reg_ctrl == ($past(s.shift[7:0]) & REG_CTRL_WMASK))
      else $error("regulator control write lost");
   delay_write_a: assert property (wr_commit && s.shift[14:9] == ADDR_DELAY
                                   |=> s.delay_reg == ($past(s.shift[7:0]) & DELAY_WMASK))
      else $error("delay control write lost");
   rsv_zero_a: assert property (s.reg_ctrl[7:6] == 2'b00 && s.delay_reg[7:5] == 3'b000)
      else $error("reserved bits not zero");
   read_back_a: assert property (!scs_n && !sclk && s.sclk_prev && s.bit_cnt == HDR_BITS
                                 && s.shift[6:1] == ADDR_REG_CTRL |=> s.dout == s.reg_ctrl)
      else $error("read returned wrong data");
   sdo_idle_a: assert property (scs_n |=> s.sdo_oe_n && s.bit_cnt == 5'h00)
      else $error("data out driven while deselected");

   write_c: cover property (wr_commit);
   demag_en_c: cover property ($rose(cfg.demag_enable));

endmodule // motor_cfg_top

// File: src/phase_cfg_if.sv
// Configuration carried from the register bank to the phase engines.
// Assumes one driver (the register bank) and any number of readers.
`timescale 1ns/100ps
interface phase_cfg_if;
   logic       delay_comp_enable;
   logic [8:0] delay_cycles;
   logic       demag_enable;
   modport src (output delay_comp_enable, output delay_cycles, output demag_enable);
   modport dst (input delay_comp_enable, input delay_cycles, input demag_enable);
endinterface

// File: src/phase_engine.sv
// One half-bridge: delay compensation, dead time and active demagnetization.
// Assumes all inputs already synchronous to ref_clk.
`timescale 1ns/100ps
module phase_engine
   import motor_cfg_pkg::*;
#(
   parameter logic [7:0] DEAD_CYC = DEAD_CYCLES,
   parameter logic [7:0] QUAL_CYC = QUAL_CYCLES
) (
   input  wire logic  ref_clk,    // Core clock
   input  wire logic  rst_n,      // Async reset
   phase_cfg_if.dst   cfg,        // Shared configuration
   input  wire logic  pwm_high,   // High-side command
   input  wire logic  pwm_low,    // Low-side command
   input  wire logic  comp_high,  // High-side demag comparator
   input  wire logic  comp_low,   // Low-side demag comparator
   output logic       gate_high,  // High-side FET on
   output logic       gate_low    // Low-side FET on
);
   phase_state_t s;
   phase_state_t nxt_s;
   logic         want_h;
   logic         want_l;
   logic         idle;
   logic         both_off;
   logic         dead_done;
   logic         start_h;
   logic         start_l;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_s = s;
      // Both edge directions see the same target delay
      if (!cfg.delay_comp_enable) begin
         nxt_s.eff_h  = pwm_high;
         nxt_s.eff_l  = pwm_low;
         nxt_s.pend_h = pwm_high;
         nxt_s.pend_l = pwm_low;
         nxt_s.dcnt   = 9'h000;
      end else if ({pwm_high, pwm_low} != {s.pend_h, s.pend_l}) begin
         // A new edge restarts the delay; pulses shorter than it are lost
         nxt_s.pend_h = pwm_high;
         nxt_s.pend_l = pwm_low;
         nxt_s.dcnt   = cfg.delay_cycles;
         if (cfg.delay_cycles == 9'h000) begin
            nxt_s.eff_h = pwm_high;
            nxt_s.eff_l = pwm_low;
         end
      end else if (s.dcnt > 9'h001) begin
         nxt_s.dcnt = s.dcnt - 9'h001;
      end else if (s.dcnt == 9'h001) begin
         nxt_s.dcnt  = 9'h000;
         nxt_s.eff_h = s.pend_h;
         nxt_s.eff_l = s.pend_l;
      end
      want_h    = s.eff_h & ~s.eff_l;
      want_l    = s.eff_l & ~s.eff_h;
      idle      = ~s.eff_h & ~s.eff_l;
      both_off  = ~s.gate_h & ~s.gate_l;
      dead_done = (s.off_cnt == DEAD_CYC);
      // Driver dead time counts from the last gate off, so a longer
      // controller gap simply wins
      if (!both_off) begin
         nxt_s.off_cnt = 8'h00;
      end else if (!dead_done) begin
         nxt_s.off_cnt = s.off_cnt + 8'h01;
      end
      // Qualify a conducting body diode only after the dead time
      if (cfg.demag_enable && idle && both_off && dead_done && comp_low) begin
         nxt_s.qual_l = (s.qual_l == QUAL_CYC) ? s.qual_l : s.qual_l + 8'h01;
      end else begin
         nxt_s.qual_l = 8'h00;
      end
      if (cfg.demag_enable && idle && both_off && dead_done && comp_high) begin
         nxt_s.qual_h = (s.qual_h == QUAL_CYC) ? s.qual_h : s.qual_h + 8'h01;
      end else begin
         nxt_s.qual_h = 8'h00;
      end
      // Low side has priority so both sides never start together
      start_l = both_off & dead_done &
                (want_l | (cfg.demag_enable & idle & (s.qual_l == QUAL_CYC)));
      start_h = both_off & dead_done & ~start_l &
                (want_h | (cfg.demag_enable & idle & (s.qual_h == QUAL_CYC)));
      if (s.gate_l) begin
         nxt_s.gate_l = s.dmg_l ? (comp_low & idle & cfg.demag_enable) : want_l;
         nxt_s.dmg_l  = s.dmg_l & nxt_s.gate_l;
      end else begin
         nxt_s.gate_l = start_l;
         nxt_s.dmg_l  = start_l & ~want_l;
      end
      if (s.gate_h) begin
         nxt_s.gate_h = s.dmg_h ? (comp_high & idle & cfg.demag_enable) : want_h;
         nxt_s.dmg_h  = s.dmg_h & nxt_s.gate_h;
      end else begin
         nxt_s.gate_h = start_h;
         nxt_s.dmg_h  = start_h & ~want_h;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= nxt_s;
      end
   end

   assign gate_high = s.gate_h;
   assign gate_low  = s.gate_l;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   no_shoot_a: assert property (!(s.gate_h && s.gate_l))
      else $error("both gates on");
   dead_gap_a: assert property ($fell(s.gate_l) |=> !s.gate_h [*2])
      else $error("high side on inside dead time");
   demag_gate_a: assert property ((s.dmg_l || s.dmg_h) |-> cfg.demag_enable)
      else $error("demag active while disabled");
   plain_on_a: assert property ($rose(s.gate_l) && !s.dmg_l |-> $past(s.eff_l))
      else $error("low gate on without command");
   qual_on_a: assert property ($rose(s.dmg_l) |-> $past(s.qual_l) == QUAL_CYC)
      else $error("demag on before qualification");
   demag_off_a: assert property (s.dmg_l && !comp_low |=> !s.gate_l)
      else $error("demag FET stays on after comparator drop");
   delay_hit_a: assert property (cfg.delay_comp_enable && s.dcnt == 9'h001
                                 && {pwm_high, pwm_low} == {s.pend_h, s.pend_l}
                                 |=> s.eff_h == $past(s.pend_h) && s.eff_l == $past(s.pend_l))
      else $error("delayed command not applied");

   demag_c: cover property ($rose(s.dmg_l));
   high_on_c: cover property ($rose(s.gate_h) && !s.dmg_h);
   delay_c: cover property (cfg.delay_comp_enable && s.dcnt == 9'h001);

endmodule // phase_engine

// File: testbench/ctrl_model.sv
// Controller model: serial master and PWM source for the regulator block.
// Assumes a 100 MHz ref_clk; every output changes just after a falling edge.
`timescale 1ns/100ps
module ctrl_model (
   input  wire logic       ref_clk,   // Core clock
   output logic            scs_n,     // Serial select
   output logic            sclk,      // Serial clock, idle low
   output logic            sdi,       // Serial data to device
   input  wire logic       sdo_out,   // Serial data from device
   input  wire logic       sdo_oe_n,  // Device drives sdo when low
   output logic [2:0]      pwm_high,  // High-side commands
   output logic [2:0]      pwm_low    // Low-side commands
);
   initial begin
      scs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
      pwm_high = 3'h0;
      pwm_low = 3'h0;
   end

   task automatic wt(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic set_pwm(input logic [2:0] h, input logic [2:0] l);
      @(negedge ref_clk);
      pwm_high = h;
      pwm_low = l;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // One 16-bit frame; sclk phases of 5 clocks leave margin over the 2-flop sync
   task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] wd,
                       output logic [7:0] rdv);
      logic [15:0] fr;
      fr = {rd, a, 1'b0, wd};
      rdv = 8'h00;
      @(negedge ref_clk);
      scs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdi = fr[i];
         wt(5);
         if (i < 8) begin
            rdv[i] = sdo_oe_n ? 1'bx : sdo_out;
         end
         sclk = 1'b1;
         wt(5);
         sclk = 1'b0;
      end
      wt(5);
      scs_n = 1'b1;
      // Stale data must not look valid between frames
      sdi = ~sdi;
      wt(6);
   endtask
endmodule // ctrl_model

// File: testbench/test_buck_delay_demag_config.sv
// Self-checking bench for the regulator, delay and demagnetization block.
// Assumes ctrl_model as serial master and PWM source; phase 0 carries the traffic.
`timescale 1ns/100ps
module test_buck_delay_demag_config;
   import motor_cfg_pkg::*;
   localparam int LIMIT = 20000;
   logic       ref_clk, rst_n, scs_n, sclk, sdi, sdo_out, sdo_oe_n;
   logic [2:0] pwm_h, pwm_l, cmp_h, cmp_l, g_h, g_l;
   logic       seq_off, cur_lim, reg_off;
   logic [1:0] vsel;
   logic [7:0] rd, reg_out;
   int         n_errors = 0;
   int         total_checks = 0;
   int         cycles = 0;

   assign reg_out = {3'h0, seq_off, cur_lim, vsel, reg_off};

   motor_cfg_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .spi_scs_n(scs_n), .spi_sclk(sclk),
      .spi_sdi(sdi), .spi_sdo_out(sdo_out), .spi_sdo_oe_n(sdo_oe_n), .pwm_high_in(pwm_h),
      .pwm_low_in(pwm_l), .demag_comparator_high(cmp_h), .demag_comparator_low(cmp_l),
      .gate_high(g_h), .gate_low(g_l), .regulator_sequencing_off(seq_off),
      .regulator_current_limit_sel(cur_lim), .regulator_voltage_sel(vsel),
      .regulator_off(reg_off));

   ctrl_model cm (.ref_clk(ref_clk), .scs_n(scs_n), .sclk(sclk), .sdi(sdi), .sdo_out(sdo_out),
      .sdo_oe_n(sdo_oe_n), .pwm_high(pwm_h), .pwm_low(pwm_l));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         n_errors++;
         $display("ERROR run length expected <%0d seen %0d", LIMIT, cycles);
         results();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("Checks %0d, mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chkn(input string nm, input int e, input int g);
      total_checks++;
      if (g != e) begin
         n_errors++;
         $display("ERROR %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] x;
      cm.xfer(1'b0, a, d, x);
   endtask

   task automatic rdr(input logic [5:0] a, output logic [7:0] d);
      cm.xfer(1'b1, a, 8'h00, d);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdr(ADDR_REG_CTRL, rd);
      chk8("regulator reg reset", 8'h00, rd);
      rdr(ADDR_DELAY, rd);
      chk8("delay reg reset", 8'h00, rd);
      chk8("regulator pins reset", 8'h00, reg_out);
      chk8("gates reset", 8'h00, {2'h0, g_h, g_l});
      $display("reset test done");
   endtask

   task automatic t_regctl();
      logic [7:0] v [5] = '{8'h15, 8'h0A, 8'h26, 8'hC0, 8'hFF};
      foreach (v[i]) begin
         wr(ADDR_REG_CTRL, v[i]);
         chk8("regulator pins", {3'h0, v[i][4:0]}, reg_out);
         rdr(ADDR_REG_CTRL, rd);
         chk8("regulator readback", v[i] & 8'h3F, rd);
      end
      $display("regulator register test done");
   endtask

   task automatic t_delayreg();
      wr(ADDR_DELAY, 8'hFF);
      rdr(ADDR_DELAY, rd);
      chk8("delay readback", 8'h1F, rd);
      wr(6'h1F, 8'hAA);
      rdr(6'h1F, rd);
      chk8("unmapped read", 8'h00, rd);
      rdr(ADDR_REG_CTRL, rd);
      chk8("regulator untouched", 8'h3F, rd);
      $display("delay register test done");
   endtask

   // Turn-on latency of one side of phase 0; long idle lets delayed turn-off finish
   task automatic lat(input logic lo, output int k);
      k = 0;
      cm.set_pwm({2'h0, ~lo}, {2'h0, lo});
      while ((lo ? g_l[0] : g_h[0]) !== 1'b1 && k < 1000) begin
         @(negedge ref_clk);
         k++;
      end
      cm.set_pwm(3'h0, 3'h0);
      cm.wt(400);
   endtask

   task automatic t_delay();
      logic [7:0] c [5] = '{8'h0F, 8'h10, 8'h11, 8'h13, 8'h1F};
      int bh, bl, k, e;
      wr(ADDR_DELAY, 8'h00);
      lat(1'b0, bh);
      lat(1'b1, bl);
      foreach (c[i]) begin
         wr(ADDR_DELAY, c[i]);
         lat(1'(i % 2), k);
         // Code 1 is 0.4 us, then 0.2 us (20 clocks) per code
         e = (!c[i][4] || c[i][3:0] == 4'h0) ? 0 : (int'(c[i][3:0]) + 1) * 20;
         chkn("delay added", e, k - ((i % 2) ? bl : bh));
      end
      wr(ADDR_DELAY, 8'h00);
      $display("delay compensation test done");
   endtask

   task automatic t_dead(input int mcu);
      int k = 0;
      logic ov = 1'b0;
      logic on = 1'b0;
      int lo = (mcu > int'(DEAD_CYCLES)) ? mcu : int'(DEAD_CYCLES);
      cm.set_pwm(3'h1, 3'h0);
      cm.wt(60);
      cm.set_pwm(3'h0, 3'h0);
      for (int t = 0; t < 200; t++) begin
         if (t == mcu) begin
            cm.set_pwm(3'h0, 3'h1);
         end else begin
            @(negedge ref_clk);
         end
         ov = ov | (g_h[0] & g_l[0]);
         on = on | g_l[0];
         if (!on && g_h[0] === 1'b0) begin
            k++;
         end
      end
      chk8("dead gap in range", 8'h01, {7'h0, k >= lo && k <= lo + 4});
      chk8("no overlap", 8'h00, {7'h0, ov});
      cm.set_pwm(3'h0, 3'h0);
      cm.wt(60);
      $display("dead time test done");
   endtask

   task automatic t_demag(input logic [7:0] en, input logic on);
      int k = 0;
      int m = 0;
      int q = int'(DEAD_CYCLES) + int'(QUAL_CYCLES);
      wr(ADDR_RECT, en);
      rdr(ADDR_RECT, rd);
      chk8("rectify readback", en, rd);
      cm.set_pwm(3'h1, 3'h0);
      cm.wt(60);
      cm.set_pwm(3'h0, 3'h0);
      cmp_l = 3'h1;
      while (g_l[0] !== 1'b1 && k < 80) begin
         @(negedge ref_clk);
         k++;
      end
      if (on) begin
         chk8("demag turn-on window", 8'h01, {7'h0, k >= q && k <= q + 10});
         cmp_l = 3'h0;
         while (g_l[0] !== 1'b0 && m < 20) begin
            @(negedge ref_clk);
            m++;
         end
         chk8("demag turn-off", 8'h01, {7'h0, m <= 5});
         // High side qualifies once the low side is released
         k = 0;
         cmp_h = 3'h1;
         while (g_h[0] !== 1'b1 && k < 80) begin
            @(negedge ref_clk);
            k++;
         end
         chk8("high demag window", 8'h01, {7'h0, k >= q - 2 && k <= q + 10});
         cmp_h = 3'h0;
         m = 0;
         while (g_h[0] !== 1'b0 && m < 20) begin
            @(negedge ref_clk);
            m++;
         end
         chk8("high demag off", 8'h01, {7'h0, m <= 5});
         cm.wt(20);
      end else begin
         chk8("no demag", 8'h00, {7'h0, g_l[0]});
      end
      cmp_l = 3'h0;
      wr(ADDR_RECT, 8'h00);
      $display("demag test done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      cmp_h = 3'h0;
      cmp_l = 3'h0;
      repeat (5) @(negedge ref_clk);
      rst_n = 1'b1;
      cm.wt(3);
      t_reset();
      t_regctl();
      t_delayreg();
      t_delay();
      t_dead(0);
      t_dead(40);
      t_demag(8'h04, 1'b0);
      t_demag(8'h08, 1'b0);
      t_demag(8'h0C, 1'b1);
      results();
   end
endmodule // test_buck_delay_demag_config
